// ### design/rkc_disp_if.sv
// Interface carrying one display write between top and write engine.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface rkc_disp_if;
	logic req;
	logic reg_sel;
	logic [7:0] data;
	logic busy;
	modport master (output req, output reg_sel, output data, input busy);
	modport slave (input req, input reg_sel, input data, output busy);
endinterface : rkc_disp_if
`default_nettype wire

// ### design/rkc_disp_wr.sv
// Display driver write engine: a two cycle select strobe per byte.
// Assumes the driver latches data on the rising edge of its select.
`timescale 1ns/1ps
`default_nettype none
module rkc_disp_wr
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Request side
	rkc_disp_if.slave req_if,
	// Driver pins
	output logic display_select_n,
	output logic display_reg_select,
	output logic [7:0] display_data
);
	logic [1:0] phase;

	// Only writes exist toward the driver; there is no read path at all
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			phase <= 2'h0;
			display_select_n <= 1'b1;
			display_reg_select <= 1'b0;
			display_data <= 8'h00;
		end
		else if (phase == 2'h0)
		begin
			if (req_if.req)
			begin
				phase <= 2'h1;
				display_reg_select <= req_if.reg_sel;
				display_data <= req_if.data;
			end
		end
		else
		begin
			phase <= phase + 2'h1;
			display_select_n <= (phase == 2'h3);
		end
	end

	assign req_if.busy = (phase != 2'h0);

	strobe_len_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		$fell(display_select_n) |=> !display_select_n ##1 display_select_n)
		else $error("Display select strobe not two cycles");
endmodule : rkc_disp_wr
`default_nettype wire

// ### design/rkc_pkg.sv
// Package for the radio user interface key scan and control block.
// Assumes a single 10 MHz clock and digitised sense levels of 8 bits.
package rkc_pkg;
	localparam int unsigned clk_mhz = 10;
	localparam int unsigned debounce_us = 20;
	localparam int unsigned debounce_cycles = debounce_us * clk_mhz;
	localparam int unsigned row_settle_cycles = 4;
	localparam int unsigned level_w = 8;
	localparam int unsigned num_rows = 3;
	localparam int unsigned num_cols = 7;
	// Threshold windows on the key sense level
	localparam logic [7:0] idle_max = 8'h08;
	localparam logic [7:0] side_one_lo = 8'h10;
	localparam logic [7:0] side_one_hi = 8'h1f;
	localparam logic [7:0] side_two_lo = 8'h20;
	localparam logic [7:0] side_two_hi = 8'h2f;
	localparam logic [7:0] col_base = 8'h30;
	localparam logic [7:0] col_step = 8'h18;
	localparam logic [7:0] alarm_min = 8'he8;
	localparam logic [7:0] accessory_none_min = 8'hf0;
	// Key codes reported to the user side
	localparam logic [4:0] key_none = 5'h00;
	localparam logic [4:0] key_talk = 5'h01;
	localparam logic [4:0] key_side_one = 5'h02;
	localparam logic [4:0] key_side_two = 5'h03;
	localparam logic [4:0] key_alarm = 5'h04;
	localparam logic [4:0] key_matrix_base = 5'h08;
	// Function key actions
	typedef enum logic [2:0] {
		rkc_act_none, rkc_act_menu, rkc_act_down, rkc_act_up, rkc_act_ok
	} rkc_action_e;
endpackage : rkc_pkg

// ### design/rkc_ui_ctrl.sv
// Top of the radio user interface control: key scan, display, serial pins.
// Assumes sense levels arrive already digitised and synchronous to ref_clk.
// Operation
// - Keypad is three rows by seven columns
// - Idle holds every row drive low
// - Key interrupt means some key pressed
// - Release rows singly until row found
// - Column comes from level at interrupt
// - Zero level without interrupt means idle
// - Interrupt with zero level is talk
// - Side keys differ by sense level
// - Full supply level means alarm key
// - Byte writes with select and register line
// - Display driver is written, never read
// - One output switches the backlight
// - Inhibit trickle charge while serial drives
// - High output pulls shared data low
// - Received serial data is inverted
// - Transmit output is inverted outward
// - Accessory interrupt then read accessory level
// - Memory plug found by serial probe
// - Three function keys map to actions
`timescale 1ns/1ps
`default_nettype none
module rkc_ui_ctrl
#(
	parameter int unsigned debounce_cycles = rkc_pkg::debounce_cycles
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Key sensing
	input wire logic key_press_irq,
	input wire logic [7:0] key_sense_level,
	output logic [1:0] keypad_row_enables_n,
	// Key result
	output logic key_valid,
	output logic [4:0] key_code,
	output logic [2:0] key_action,
	// Accessory sensing
	input wire logic accessory_irq,
	input wire logic [7:0] accessory_sense_level,
	input wire logic memory_plug_ack,
	output logic accessory_valid,
	output logic [7:0] accessory_type_level,
	output logic memory_plug,
	// Display write request
	input wire logic disp_wr_req,
	input wire logic disp_wr_reg_sel,
	input wire logic [7:0] disp_wr_data,
	output logic disp_wr_busy,
	output logic display_select_n,
	output logic display_reg_select,
	output logic [7:0] display_data,
	// Backlight and charger
	input wire logic backlight_req,
	output logic backlight_on,
	output logic charger_inhibit,
	// Serial user side
	input wire logic serial_enable,
	input wire logic uart_tx_data,
	input wire logic iic_mode,
	input wire logic iic_clk_out,
	input wire logic iic_data_out,
	output logic serial_rx_data,
	// Serial pins
	input wire logic serial_in_pin_i,
	output logic serial_in_pin_o,
	output logic serial_in_pin_oe_n,
	output logic serial_out_pin
);
	typedef enum {
		rkc_st_idle, rkc_st_debounce, rkc_st_release, rkc_st_settle,
		rkc_st_report
	} rkc_state_e;

	rkc_state_e state;
	logic [15:0] count;
	logic [7:0] level_at_irq;
	logic [1:0] row_step;
	logic [2:0] column;
	logic [4:0] next_code;
	logic [2:0] next_action;
	logic class_matrix;
	logic disp_busy;

	rkc_disp_if disp_bus ();

	// Classify a sense level into key identity or keypad column
	always_comb
	begin
		next_code = rkc_pkg::key_none;
		class_matrix = 1'b0;
		column = 3'h0;
		if (level_at_irq <= rkc_pkg::idle_max)
			next_code = rkc_pkg::key_talk;
		else if (level_at_irq >= rkc_pkg::alarm_min)
			next_code = rkc_pkg::key_alarm;
		else if (level_at_irq >= rkc_pkg::side_one_lo &&
			level_at_irq <= rkc_pkg::side_one_hi)
			next_code = rkc_pkg::key_side_one;
		else if (level_at_irq >= rkc_pkg::side_two_lo &&
			level_at_irq <= rkc_pkg::side_two_hi)
			next_code = rkc_pkg::key_side_two;
		else if (level_at_irq >= rkc_pkg::col_base)
		begin
			class_matrix = 1'b1;
			for (int i = 1; i < rkc_pkg::num_cols; i++)
				if (level_at_irq >= 8'(rkc_pkg::col_base +
					rkc_pkg::col_step * i))
					column = 3'(i);
		end
	end

	// Function keys sit in the first column of the matrix
	always_comb
	begin
		next_action = 3'(rkc_pkg::rkc_act_none);
		if (class_matrix && column == 3'h0)
			case (row_step)
				2'h0: next_action = 3'(rkc_pkg::rkc_act_menu);
				2'h1: next_action = 3'(rkc_pkg::rkc_act_down);
				2'h2: next_action = 3'(rkc_pkg::rkc_act_up);
				default: next_action = 3'(rkc_pkg::rkc_act_ok);
			endcase
	end

	// Scan sequencer
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state <= rkc_st_idle;
			count <= 16'h0000;
			level_at_irq <= 8'h00;
			row_step <= 2'h0;
			keypad_row_enables_n <= 2'b00;
			key_valid <= 1'b0;
			key_code <= rkc_pkg::key_none;
			key_action <= 3'h0;
		end
		else
		begin
			key_valid <= 1'b0;
			case (state)
				rkc_st_idle:
				begin
					keypad_row_enables_n <= 2'b00;
					// Zero level with no interrupt stays here
					if (key_press_irq)
					begin
						level_at_irq <= key_sense_level;
						count <= 16'h0000;
						state <= rkc_st_debounce;
					end
				end
				rkc_st_debounce:
				begin
					// A drifting level restarts the interval
					if (!key_press_irq)
						state <= rkc_st_idle;
					else if (key_sense_level != level_at_irq)
					begin
						level_at_irq <= key_sense_level;
						count <= 16'h0000;
					end
					else if (count >= 16'(debounce_cycles - 1))
					begin
						row_step <= 2'h0;
						state <= class_matrix ? rkc_st_release : rkc_st_report;
					end
					else
						count <= count + 16'h0001;
				end
				rkc_st_release:
				begin
					// Release one row only; rows cannot be sensed in parallel
					keypad_row_enables_n <= 2'(2'b01 << row_step);
					count <= 16'h0000;
					state <= rkc_st_settle;
				end
				rkc_st_settle:
				begin
					if (count >= 16'(rkc_pkg::row_settle_cycles - 1))
					begin
						// Level dropping means the released row holds the key
						if (key_sense_level <= rkc_pkg::idle_max ||
							row_step == 2'h2)
							state <= rkc_st_report;
						else
						begin
							row_step <= row_step + 2'h1;
							state <= rkc_st_release;
						end
					end
					else
						count <= count + 16'h0001;
				end
				rkc_st_report:
				begin
					keypad_row_enables_n <= 2'b00;
					key_valid <= 1'b1;
					key_action <= next_action;
					key_code <= class_matrix ? 5'(rkc_pkg::key_matrix_base +
						5'(column) * 5'd3 + 5'(row_step)) : next_code;
					state <= rkc_st_idle;
				end
				default: state <= rkc_st_idle;
			endcase
		end
	end

	// Accessory detection
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			accessory_valid <= 1'b0;
			accessory_type_level <= 8'h00;
			memory_plug <= 1'b0;
		end
		else
		begin
			accessory_valid <= 1'b0;
			if (accessory_irq)
			begin
				accessory_valid <= 1'b1;
				accessory_type_level <= accessory_sense_level;
			end
			// No type resistor: presence only shows as a serial answer
			if (iic_mode && memory_plug_ack)
				memory_plug <= 1'b1;
			else if (accessory_irq)
				memory_plug <= 1'b0;
		end
	end

	// Serial pins, backlight and charger
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			serial_rx_data <= 1'b1;
			serial_in_pin_o <= 1'b0;
			serial_in_pin_oe_n <= 1'b1;
			serial_out_pin <= 1'b0;
			charger_inhibit <= 1'b0;
			backlight_on <= 1'b0;
		end
		else
		begin
			backlight_on <= backlight_req;
			charger_inhibit <= serial_enable;
			serial_rx_data <= ~serial_in_pin_i;
			serial_in_pin_o <= iic_mode & serial_enable & ~iic_data_out;
			serial_in_pin_oe_n <= ~(iic_mode & serial_enable);
			serial_out_pin <= ~(iic_mode ? iic_clk_out : uart_tx_data);
		end
	end

	assign disp_bus.req = disp_wr_req;
	assign disp_bus.reg_sel = disp_wr_reg_sel;
	assign disp_bus.data = disp_wr_data;
	assign disp_busy = disp_bus.busy;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			disp_wr_busy <= 1'b0;
		else
			disp_wr_busy <= disp_busy | disp_wr_req;
	end

	rkc_disp_wr i_rkc_disp_wr
	(
		.ref_clk(ref_clk),
		.reset(reset),
		.req_if(disp_bus),
		.display_select_n(display_select_n),
		.display_reg_select(display_reg_select),
		.display_data(display_data)
	);

	idle_rows_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(state == rkc_st_idle) |-> keypad_row_enables_n == 2'b00)
		else $error("Rows not active while idle");
	idle_hold_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(state == rkc_st_idle && !key_press_irq) |=>
		state == rkc_st_idle && !key_valid)
		else $error("Key reported without interrupt");
	irq_start_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(state == rkc_st_idle && key_press_irq) |=>
		state == rkc_st_debounce && level_at_irq == $past(key_sense_level))
		else $error("Interrupt not captured");
	key_pulse_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		key_valid |=> !key_valid)
		else $error("Key result pulse too long");
	// Row two has no release pin, so its step leaves both drives active
	one_row_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(state == rkc_st_settle) |->
		$countones(keypad_row_enables_n) == ((row_step == 2'h2) ? 0 : 1))
		else $error("Wrong rows released");
	talk_key_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(state == rkc_st_report && level_at_irq <= rkc_pkg::idle_max) |=>
		key_valid && key_code == rkc_pkg::key_talk)
		else $error("Talk key misdecoded");
	side_key_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(state == rkc_st_report && level_at_irq >= rkc_pkg::side_one_lo &&
		level_at_irq <= rkc_pkg::side_one_hi) |=>
		key_code == rkc_pkg::key_side_one)
		else $error("Side key misdecoded");
	alarm_key_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(state == rkc_st_report && level_at_irq >= rkc_pkg::alarm_min) |=>
		key_code == rkc_pkg::key_alarm)
		else $error("Alarm key misdecoded");
	rx_invert_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		##1 serial_rx_data == !$past(serial_in_pin_i))
		else $error("Receive data not inverted");
	tx_invert_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(!iic_mode && uart_tx_data) |=> !serial_out_pin)
		else $error("Transmit data not inverted");
	charge_off_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		serial_enable |=> charger_inhibit)
		else $error("Charger not inhibited");
	iic_pull_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(iic_mode && serial_enable && !iic_data_out) |=>
		!serial_in_pin_oe_n && serial_in_pin_o)
		else $error("Shared data line not pulled");
	backlight_follow_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		##1 backlight_on == $past(backlight_req))
		else $error("Backlight does not follow request");
	accessory_type_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		accessory_irq |=> accessory_valid &&
		accessory_type_level == $past(accessory_sense_level))
		else $error("Accessory level not captured");
	plug_set_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		(iic_mode && memory_plug_ack) |=> memory_plug)
		else $error("Memory plug not flagged");
	disp_busy_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		disp_wr_req |=> disp_wr_busy)
		else $error("Display write not shown busy");
endmodule : rkc_ui_ctrl
`default_nettype wire

// ### verif/rkc_keypad_model.sv
// Keypad and key sense model standing behind the key scan inputs.
// Assumes row drive bits come straight from the design, 0 = driven.
`timescale 1ns/1ps
`default_nettype none
module rkc_keypad_model
(
	// Key held by the bench
	input wire logic press,
	input wire logic [1:0] row,
	input wire logic [2:0] col,
	input wire logic ovr,
	input wire logic [7:0] ovr_level,
	// Row drives from the design
	input wire logic [1:0] keypad_row_enables_n,
	// Sense outputs
	output logic key_press_irq,
	output logic [7:0] key_sense_level
);
	logic row_live;
	logic [7:0] col_level;
	// Row two has no release line of its own, so it stays live in a scan
	assign row_live = row == 2'h2 || !keypad_row_enables_n[row[0]];
	assign col_level = rkc_pkg::col_base + col * rkc_pkg::col_step;
	assign key_press_irq = press;
	assign key_sense_level = !press ? 8'h00 : ovr ? ovr_level :
		row_live ? col_level : 8'h00;
endmodule : rkc_keypad_model
`default_nettype wire

// ### verif/tb_rkc_ui_ctrl.sv
// Bench for the user interface control: key scan, display, serial pins.
// Assumes rkc_keypad_model stands in for the keypad and side keys.
`timescale 1ns/1ps
`default_nettype none
module tb_rkc_ui_ctrl;
	logic ref_clk = 1'h0, reset = 1'h1, press = 1'h0, ovr = 1'h0;
	logic [1:0] k_row = 2'h0, keypad_row_enables_n;
	logic [2:0] k_col = 3'h0, key_action;
	logic [7:0] ovr_level = 8'h00, key_sense_level, display_data;
	logic [7:0] accessory_sense_level = 8'h00, disp_wr_data = 8'h00;
	logic [7:0] accessory_type_level;
	logic [4:0] key_code;
	logic key_press_irq, key_valid, accessory_valid, memory_plug;
	logic accessory_irq = 1'h0, memory_plug_ack = 1'h0, disp_wr_req = 1'h0;
	logic disp_wr_reg_sel = 1'h0, backlight_req = 1'h0, iic_mode = 1'h0;
	logic serial_enable = 1'h0, uart_tx_data = 1'h0, iic_clk_out = 1'h0;
	logic iic_data_out = 1'h0, serial_in_pin_i = 1'h0;
	logic disp_wr_busy, display_select_n, display_reg_select, backlight_on;
	logic charger_inhibit, serial_rx_data, serial_in_pin_o;
	logic serial_in_pin_oe_n, serial_out_pin;
	int n_errors = 0, total_checks = 0, n_kv = 0;

	// Short debounce keeps the run brief; row settle time stays at the package value
	rkc_ui_ctrl #(.debounce_cycles(4)) i_rkc_ui_ctrl (.ref_clk, .reset,
		.key_press_irq, .key_sense_level, .keypad_row_enables_n, .key_valid,
		.key_code, .key_action, .accessory_irq, .accessory_sense_level,
		.memory_plug_ack, .accessory_valid, .accessory_type_level,
		.memory_plug, .disp_wr_req, .disp_wr_reg_sel, .disp_wr_data,
		.disp_wr_busy, .display_select_n, .display_reg_select, .display_data,
		.backlight_req, .backlight_on, .charger_inhibit, .serial_enable,
		.uart_tx_data, .iic_mode, .iic_clk_out, .iic_data_out, .serial_rx_data,
		.serial_in_pin_i, .serial_in_pin_o, .serial_in_pin_oe_n,
		.serial_out_pin);
	rkc_keypad_model i_rkc_keypad_model (.press, .row(k_row), .col(k_col),
		.ovr, .ovr_level, .keypad_row_enables_n, .key_press_irq,
		.key_sense_level);

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
		if (key_valid === 1'h1)
			n_kv++;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : cyc

	task automatic key(input logic [1:0] r, input logic [2:0] c,
		input logic o, input logic [7:0] lv, input logic [4:0] code,
		input logic [2:0] act);
		int i;
		@(posedge ref_clk);
		k_row <= r;
		k_col <= c;
		ovr <= o;
		ovr_level <= lv;
		press <= 1'h1;
		for (i = 0; i < 60 && key_valid !== 1'h1; i++)
			@(negedge ref_clk);
		chk(8'(key_valid), 8'h01);
		chk(8'(key_code), 8'(code));
		chk(8'(key_action), 8'(act));
		@(posedge ref_clk);
		press <= 1'h0;
		cyc(10);
		chk(8'(keypad_row_enables_n), 8'h00);
	endtask : key

	task automatic disp(input logic rs, input logic [7:0] d);
		int lows;
		lows = 0;
		@(posedge ref_clk);
		disp_wr_req <= 1'h1;
		disp_wr_reg_sel <= rs;
		disp_wr_data <= d;
		@(posedge ref_clk);
		disp_wr_req <= 1'h0;
		@(negedge ref_clk);
		chk(8'(disp_wr_busy), 8'h01);
		repeat (7)
		begin
			@(negedge ref_clk);
			lows += int'(display_select_n === 1'h0);
		end
		chk(8'(lows), 8'h02);
		chk(display_data, d);
		chk(8'(display_reg_select), 8'(rs));
		chk(8'(disp_wr_busy), 8'h00);
	endtask : disp

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// Roughly fifteen times the expected run length
	initial
	begin
		#(100 * 5000);
		n_errors++;
		summarize();
	end

	initial
	begin
		int i;
		repeat (4) @(posedge ref_clk);
		reset <= 1'h0;
		cyc(1);
		chk(8'(keypad_row_enables_n), 8'h00);
		chk(8'(display_select_n), 8'h01);
		chk(8'(serial_in_pin_oe_n), 8'h01);
		$display("test reset done");
		// A press shorter than the debounce must vanish unreported
		@(posedge ref_clk);
		press <= 1'h1;
		repeat (2) @(posedge ref_clk);
		press <= 1'h0;
		cyc(20);
		chk(8'(n_kv), 8'h00);
		$display("test idle done");
		key(2'h0, 3'h0, 1'h1, 8'h00, rkc_pkg::key_talk, 3'h0);
		key(2'h0, 3'h0, 1'h1, 8'h18, rkc_pkg::key_side_one, 3'h0);
		key(2'h0, 3'h0, 1'h1, 8'h28, rkc_pkg::key_side_two, 3'h0);
		key(2'h0, 3'h0, 1'h1, 8'hff, rkc_pkg::key_alarm, 3'h0);
		for (int r = 0; r < 3; r++)
			for (int c = 0; c < 7; c += 6)
				key(2'(r), 3'(c), 1'h0, 8'h00, 5'(8 + c * 3 + r),
					3'(c == 0 ? r + 1 : 0));
		$display("test keys done");
		disp(1'h0, 8'ha5);
		disp(1'h1, 8'h3c);
		$display("test display done");
		for (int v = 0; v < 4; v++)
		begin
			@(posedge ref_clk);
			backlight_req <= v[0];
			serial_enable <= v[0];
			serial_in_pin_i <= v[0];
			uart_tx_data <= v[0];
			iic_clk_out <= !v[0];
			// Data low while driving, so the pull-down path is exercised
			iic_data_out <= !v[0];
			iic_mode <= v[1];
			cyc(2);
			chk(8'(backlight_on), 8'(v[0]));
			chk(8'(charger_inhibit), 8'(v[0]));
			chk(8'(serial_rx_data), 8'(!v[0]));
			chk(8'(serial_out_pin), 8'(v[1] ^ !v[0]));
			chk(8'(serial_in_pin_o), 8'(v[1] & v[0]));
			if (v[1])
				chk(8'(serial_in_pin_oe_n), 8'(!v[0]));
		end
		$display("test serial done");
		@(posedge ref_clk);
		memory_plug_ack <= 1'h1;
		cyc(2);
		chk(8'(memory_plug), 8'h01);
		@(posedge ref_clk);
		memory_plug_ack <= 1'h0;
		accessory_sense_level <= 8'h5a;
		accessory_irq <= 1'h1;
		@(posedge ref_clk);
		accessory_irq <= 1'h0;
		for (i = 0; i < 10 && accessory_valid !== 1'h1; i++)
			@(negedge ref_clk);
		chk(8'(accessory_valid), 8'h01);
		chk(accessory_type_level, 8'h5a);
		cyc(2);
		chk(8'(memory_plug), 8'h00);
		$display("test accessory done");
		summarize();
	end
endmodule : tb_rkc_ui_ctrl
`default_nettype wire
